// File: rtl/mstx_consts.svh
`ifndef MSTX_CONSTS_SVH
`define MSTX_CONSTS_SVH

// bus geometry
`define MSTX_ADDR_W 8
`define MSTX_DATA_W 32

// register byte offsets
`define MSTX_OFF_INSTR 8'h00
`define MSTX_OFF_ACC 8'h04
`define MSTX_OFF_STATUS 8'h08
`define MSTX_OFF_TBLPTR 8'h0C
`define MSTX_OFF_TBLHIGH 8'h10
`define MSTX_OFF_PC 8'h14
`define MSTX_OFF_MEMADDR 8'h18
`define MSTX_OFF_MEMDATA 8'h1C

// status word field positions
`define MSTX_FLAG_CARRY_BIT 0
`define MSTX_FLAG_HALF_CARRY_BIT 1
`define MSTX_FLAG_NULL_BIT 2
`define MSTX_FLAG_OVERFLOW_BIT 3
`define MSTX_FLAG_POWERDOWN_BIT 4
`define MSTX_FLAG_WATCHDOG_TIMEOUT_BIT 5
`define MSTX_FLAGS_W 6
`define MSTX_STAT_BUSY_BIT 8
`define MSTX_STAT_SKIPPED_BIT 9
`define MSTX_STAT_CYCLES_LSB 10
`define MSTX_STAT_ILLEGAL_BIT 12

// program memory geometry
`define MSTX_PC_W 12
`define MSTX_PAGE_W 4
`define MSTX_ROM_W 16
`define MSTX_LAST_PAGE 4'hF

// reset values
`define MSTX_ACC_RST 8'h00
`define MSTX_FLAGS_RST 6'h00
`define MSTX_PC_RST 12'h000
`define MSTX_TBLPTR_RST 8'h00
`define MSTX_TBLHIGH_RST 8'h00
`define MSTX_MEMADDR_RST 8'h00

// instruction cycle counts
`define MSTX_PLAIN_CYCLES 2'h1
`define MSTX_SKIP_CYCLES 2'h2

// bus answers
`define MSTX_RESP_OKAY 2'h0
`define MSTX_RESP_SLVERR 2'h2

`endif

// File: rtl/mstx_data_ram.sv
// data memory, read-first, registered read data
module mstx_data_ram (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:255];
	logic [7:0] rdata_reg;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= mem[addr_i];
		end
	end

	assign rdata_o = rdata_reg;
endmodule

// File: rtl/mstx_exec_core.sv
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`include "mstx_consts.svh"
// Operation
// - nibble exchange: swapped byte into accumulator
// - null byte test skips, two cycles
// - load byte to accumulator, skip if null
// - clear bit test skips, two cycles
// - current page table word to memory, latch
// - last page table word to memory, latch
// - accumulator xor byte into accumulator, null flag
// - accumulator xor byte into memory, null flag
// - accumulator xor constant into accumulator
// - decrement byte, store, skip when zero
module mstx_exec_core (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic [`MSTX_ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [`MSTX_ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I
);
	mstx_pkg::mstx_state_t state_reg;
	mstx_pkg::mstx_instr_t instr_reg;
	logic [`MSTX_FLAGS_W-1:0] flags_reg;
	logic [7:0] acc_reg;
	logic [7:0] table_pointer_reg;
	logic [7:0] table_high_latch_reg;
	logic [7:0] memaddr_reg;
	logic [`MSTX_PC_W-1:0] pc_reg;
	logic skipped_reg;
	logic [1:0] cycles_reg;
	logic illegal_reg;
	logic mem_view_ok_reg;

	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, rpend_reg;
	logic [1:0] bresp_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [`MSTX_ADDR_W-1:0] awaddr_reg;
	logic [`MSTX_ADDR_W-1:0] araddr_reg;

	logic [7:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic ram_we;
	logic [`MSTX_PC_W-1:0] rom_addr;
	logic [`MSTX_ROM_W-1:0] rom_rdata;

	logic busy;
	logic [31:0] status_word;
	logic [32:0] wr_sel;
	logic [32:0] rd_sel;
	logic [31:0] wr_val;
	logic wr_err;
	logic do_write;
	logic wr_ok;
	logic launch;
	logic exec;
	logic [7:0] xor_src;
	logic [7:0] xor_res;
	logic [7:0] dec_res;
	logic bit_val;
	logic skip_now;
	logic is_xor;
	logic is_table;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// register readback, top bit flags an unmapped address
	function automatic logic [32:0] reg_value(input logic [`MSTX_ADDR_W-1:0] a);
		logic [32:0] v;
		v = {1'b0, 32'h00000000};
		case (a)
			`MSTX_OFF_INSTR: v[23:0] = instr_reg;
			`MSTX_OFF_ACC: v[7:0] = acc_reg;
			`MSTX_OFF_STATUS: v[31:0] = status_word;
			`MSTX_OFF_TBLPTR: v[7:0] = table_pointer_reg;
			`MSTX_OFF_TBLHIGH: v[7:0] = table_high_latch_reg;
			`MSTX_OFF_PC: v[`MSTX_PC_W-1:0] = pc_reg;
			`MSTX_OFF_MEMADDR: v[7:0] = memaddr_reg;
			`MSTX_OFF_MEMDATA: v[7:0] = ram_rdata;
			default: v[32] = 1'b1;
		endcase
		return v;
	endfunction

	assign busy = state_reg != mstx_pkg::ST_IDLE;
	assign exec = state_reg == mstx_pkg::ST_EXEC;
	assign status_word = {19'h00000, illegal_reg, cycles_reg, skipped_reg, busy, 2'h0, flags_reg};
	// readback views follow every register the mux reads
	always_comb begin
		wr_sel = reg_value(awaddr_reg);
		rd_sel = reg_value(araddr_reg);
	end
	assign wr_err = wr_sel[32] | busy;
	assign wr_val = merge_bytes(wr_sel[31:0], wdata_reg, wstrb_reg);
	assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
	assign wr_ok = do_write && !wr_err;
	assign launch = wr_ok && awaddr_reg == `MSTX_OFF_INSTR;

	// operand and result paths
	always_comb begin
		is_xor = instr_reg.op == mstx_pkg::OP_XOR_ACC
			|| instr_reg.op == mstx_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY
			|| instr_reg.op == mstx_pkg::OP_XOR_IMM;
		is_table = instr_reg.op == mstx_pkg::OP_TABLE_FETCH_CURRENT_PAGE
			|| instr_reg.op == mstx_pkg::OP_TABLE_FETCH_LAST_PAGE;
		xor_src = (instr_reg.op == mstx_pkg::OP_XOR_IMM) ? instr_reg.imm : ram_rdata;
		xor_res = acc_reg ^ xor_src;
		dec_res = ram_rdata - 8'h01;
		bit_val = ram_rdata[instr_reg.bit_sel];
		case (instr_reg.op)
			mstx_pkg::OP_SKIP_WHEN_NULL: skip_now = ram_rdata == 8'h00;
			mstx_pkg::OP_LOAD_AND_SKIP_WHEN_NULL: skip_now = ram_rdata == 8'h00;
			mstx_pkg::OP_BIT_SKIP_WHEN_CLEAR: skip_now = !bit_val;
			mstx_pkg::OP_DECREMENT_AND_SKIP: skip_now = dec_res == 8'h00;
			default: skip_now = 1'b0;
		endcase
	end

	// data memory port: execution owns it while busy
	always_comb begin
		ram_addr = busy ? instr_reg.addr : memaddr_reg;
		ram_we = 1'b0;
		ram_wdata = wr_val[7:0];
		if (exec) begin
			case (instr_reg.op)
				mstx_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY: begin
					ram_we = 1'b1;
					ram_wdata = xor_res;
				end
				mstx_pkg::OP_DECREMENT_AND_SKIP: begin
					ram_we = 1'b1;
					ram_wdata = dec_res;
				end
				mstx_pkg::OP_TABLE_FETCH_CURRENT_PAGE,
				mstx_pkg::OP_TABLE_FETCH_LAST_PAGE: begin
					ram_we = 1'b1;
					ram_wdata = rom_rdata[7:0];
				end
				default: ram_we = 1'b0;
			endcase
		end else if (wr_ok && awaddr_reg == `MSTX_OFF_MEMDATA) begin
			ram_we = 1'b1;
		end
	end

	// table address: current page from pc, or the last page
	always_comb begin
		if (instr_reg.op == mstx_pkg::OP_TABLE_FETCH_LAST_PAGE) begin
			rom_addr = {`MSTX_LAST_PAGE, table_pointer_reg};
		end else begin
			rom_addr = {pc_reg[`MSTX_PC_W-1 -: `MSTX_PAGE_W], table_pointer_reg};
		end
	end

	mstx_data_ram u_ram (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.addr_i(ram_addr),
		.we_i(ram_we),
		.wdata_i(ram_wdata),
		.rdata_o(ram_rdata)
	);

	mstx_table_rom u_rom (
		.clk_i(CLOCK_I),
		.rst_n_i(RESET_N_I),
		.addr_i(rom_addr),
		.rdata_o(rom_rdata)
	);

	// write channels
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `MSTX_RESP_OKAY;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (S_AXI_AWVALID_I && awready_reg) begin
				awready_reg <= 1'b0;
				awaddr_reg <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && wready_reg) begin
				wready_reg <= 1'b0;
				wdata_reg <= S_AXI_WDATA_I;
				wstrb_reg <= S_AXI_WSTRB_I;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_err ? `MSTX_RESP_SLVERR : `MSTX_RESP_OKAY;
			end
			if (bvalid_reg && S_AXI_BREADY_I) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// read channels, memory data waits for a settled view
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			arready_reg <= 1'b1;
			rpend_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= `MSTX_RESP_OKAY;
			rdata_reg <= 32'h00000000;
			araddr_reg <= 8'h00;
			mem_view_ok_reg <= 1'b0;
		end else begin
			mem_view_ok_reg <= !busy && !ram_we && !(wr_ok && awaddr_reg == `MSTX_OFF_MEMADDR);
			if (S_AXI_ARVALID_I && arready_reg) begin
				arready_reg <= 1'b0;
				araddr_reg <= S_AXI_ARADDR_I;
				rpend_reg <= 1'b1;
			end
			if (rpend_reg && (araddr_reg != `MSTX_OFF_MEMDATA || mem_view_ok_reg)) begin
				rpend_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_sel[31:0];
				rresp_reg <= rd_sel[32] ? `MSTX_RESP_SLVERR : `MSTX_RESP_OKAY;
			end
			if (rvalid_reg && S_AXI_RREADY_I) begin
				rvalid_reg <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// sequencer: fetch operand, execute, optional dummy cycle
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			state_reg <= mstx_pkg::ST_IDLE;
		end else begin
			unique case (state_reg)
				mstx_pkg::ST_IDLE: if (launch) state_reg <= mstx_pkg::ST_FETCH;
				mstx_pkg::ST_FETCH: state_reg <= mstx_pkg::ST_EXEC;
				mstx_pkg::ST_EXEC: state_reg <= skip_now ? mstx_pkg::ST_DUMMY : mstx_pkg::ST_IDLE;
				mstx_pkg::ST_DUMMY: state_reg <= mstx_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			instr_reg <= mstx_pkg::mstx_instr_t'(24'h000000);
		end else if (launch) begin
			instr_reg <= mstx_pkg::mstx_instr_t'(wr_val[23:0]);
		end
	end

	// accumulator
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			acc_reg <= `MSTX_ACC_RST;
		end else if (exec) begin
			case (instr_reg.op)
				mstx_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: acc_reg <= {ram_rdata[3:0], ram_rdata[7:4]};
				mstx_pkg::OP_LOAD_AND_SKIP_WHEN_NULL: acc_reg <= ram_rdata;
				mstx_pkg::OP_XOR_ACC, mstx_pkg::OP_XOR_IMM: acc_reg <= xor_res;
				default: acc_reg <= acc_reg;
			endcase
		end else if (wr_ok && awaddr_reg == `MSTX_OFF_ACC) begin
			acc_reg <= wr_val[7:0];
		end
	end

	// status flags: execution moves only the null flag, and only on xor
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			flags_reg <= `MSTX_FLAGS_RST;
		end else if (exec && is_xor) begin
			flags_reg[`MSTX_FLAG_NULL_BIT] <= xor_res == 8'h00;
		end else if (wr_ok && awaddr_reg == `MSTX_OFF_STATUS) begin
			flags_reg <= wr_val[`MSTX_FLAGS_W-1:0];
		end
	end

	// table pointer and table-high latch
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			table_pointer_reg <= `MSTX_TBLPTR_RST;
			table_high_latch_reg <= `MSTX_TBLHIGH_RST;
		end else begin
			if (exec && is_table) begin
				table_high_latch_reg <= rom_rdata[15:8];
			end
			if (wr_ok && awaddr_reg == `MSTX_OFF_TBLPTR) begin
				table_pointer_reg <= wr_val[7:0];
			end
		end
	end

	// data memory window address
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			memaddr_reg <= `MSTX_MEMADDR_RST;
		end else if (wr_ok && awaddr_reg == `MSTX_OFF_MEMADDR) begin
			memaddr_reg <= wr_val[7:0];
		end
	end

	// program counter and last-instruction status
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			pc_reg <= `MSTX_PC_RST;
			skipped_reg <= 1'b0;
			cycles_reg <= 2'h0;
			illegal_reg <= 1'b0;
		end else if (exec) begin
			pc_reg <= pc_reg + 12'h001;
			skipped_reg <= skip_now;
			cycles_reg <= skip_now ? `MSTX_SKIP_CYCLES : `MSTX_PLAIN_CYCLES;
			illegal_reg <= instr_reg.op > mstx_pkg::OP_DECREMENT_AND_SKIP;
		end else if (state_reg == mstx_pkg::ST_DUMMY) begin
			pc_reg <= pc_reg + 12'h001;
		end else if (wr_ok && awaddr_reg == `MSTX_OFF_PC) begin
			pc_reg <= wr_val[`MSTX_PC_W-1:0];
		end
	end

	assign S_AXI_AWREADY_O = awready_reg;
	assign S_AXI_WREADY_O = wready_reg;
	assign S_AXI_BVALID_O = bvalid_reg;
	assign S_AXI_BRESP_O = bresp_reg;
	assign S_AXI_ARREADY_O = arready_reg;
	assign S_AXI_RVALID_O = rvalid_reg;
	assign S_AXI_RDATA_O = rdata_reg;
	assign S_AXI_RRESP_O = rresp_reg;

	// checks
	sequence exec_s(mstx_pkg::mstx_op_t op);
		state_reg == mstx_pkg::ST_EXEC && instr_reg.op == op;
	endsequence

	sequence fetch_s(mstx_pkg::mstx_op_t op);
		state_reg == mstx_pkg::ST_FETCH && instr_reg.op == op;
	endsequence

	sequence skip_tail_s;
		state_reg == mstx_pkg::ST_DUMMY ##1 state_reg == mstx_pkg::ST_IDLE;
	endsequence

	nib_exch_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_NIBBLE_EXCHANGE_TO_ACC) |-> !ram_we ##1
		acc_reg == {$past(ram_rdata[3:0]), $past(ram_rdata[7:4])} && $stable(flags_reg))
		else $error("nibble exchange result wrong");

	skip_null_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_SKIP_WHEN_NULL) |->
		if (ram_rdata == 8'h00) (##1 skip_tail_s) else (##1 state_reg == mstx_pkg::ST_IDLE))
		else $error("null byte skip timing wrong");

	load_skip_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_LOAD_AND_SKIP_WHEN_NULL) |=> acc_reg == $past(ram_rdata)
		&& skipped_reg == ($past(ram_rdata) == 8'h00) && $stable(flags_reg))
		else $error("load and skip wrong");

	bit_skip_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_BIT_SKIP_WHEN_CLEAR) |-> !ram_we ##1
		(state_reg == mstx_pkg::ST_DUMMY) == !$past(bit_val) && $stable(acc_reg))
		else $error("bit skip wrong");

	tab_cur_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		fetch_s(mstx_pkg::OP_TABLE_FETCH_CURRENT_PAGE) |->
		rom_addr == {pc_reg[`MSTX_PC_W-1 -: `MSTX_PAGE_W], table_pointer_reg}
		##1 ram_we && ram_wdata == rom_rdata[7:0]
		##1 table_high_latch_reg == $past(rom_rdata[15:8]))
		else $error("current page table fetch wrong");

	tab_last_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		fetch_s(mstx_pkg::OP_TABLE_FETCH_LAST_PAGE) |->
		rom_addr == {`MSTX_LAST_PAGE, table_pointer_reg}
		##1 ram_we && ram_wdata == rom_rdata[7:0]
		##1 table_high_latch_reg == $past(rom_rdata[15:8]) && $stable(flags_reg))
		else $error("last page table fetch wrong");

	xor_acc_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_XOR_ACC) |=> acc_reg == ($past(acc_reg) ^ $past(ram_rdata))
		&& ((flags_reg ^ $past(flags_reg)) & 6'h3B) == 6'h00)
		else $error("xor into accumulator wrong");

	xor_mem_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY) |-> ram_we && ram_addr == instr_reg.addr
		&& ram_wdata == (acc_reg ^ ram_rdata) ##1 $stable(acc_reg))
		else $error("xor into memory wrong");

	xor_imm_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_XOR_IMM) |=> acc_reg == ($past(acc_reg) ^ $past(instr_reg.imm)))
		else $error("xor immediate wrong");

	dec_skip_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec_s(mstx_pkg::OP_DECREMENT_AND_SKIP) |-> ram_we && ram_wdata == ram_rdata - 8'h01
		##1 (state_reg == mstx_pkg::ST_DUMMY) == ($past(ram_rdata) == 8'h01))
		else $error("decrement and skip wrong");

	null_flag_a: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		exec && is_xor |=> flags_reg[`MSTX_FLAG_NULL_BIT] == ($past(xor_res) == 8'h00))
		else $error("null flag does not follow xor result");
endmodule

// File: rtl/mstx_pkg.sv
package mstx_pkg;
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_NIBBLE_EXCHANGE_TO_ACC = 4'h1,
		OP_SKIP_WHEN_NULL = 4'h2,
		OP_LOAD_AND_SKIP_WHEN_NULL = 4'h3,
		OP_BIT_SKIP_WHEN_CLEAR = 4'h4,
		OP_TABLE_FETCH_CURRENT_PAGE = 4'h5,
		OP_TABLE_FETCH_LAST_PAGE = 4'h6,
		OP_XOR_ACC = 4'h7,
		OP_EXCLUSIVE_OR_INTO_MEMORY = 4'h8,
		OP_XOR_IMM = 4'h9,
		OP_DECREMENT_AND_SKIP = 4'hA
	} mstx_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FETCH = 2'h1,
		ST_EXEC = 2'h2,
		ST_DUMMY = 2'h3
	} mstx_state_t;

	typedef struct packed {
		logic [7:0] imm;
		logic [7:0] addr;
		logic spare;
		logic [2:0] bit_sel;
		mstx_op_t op;
	} mstx_instr_t;
endpackage

// File: rtl/mstx_table_rom.sv
`include "mstx_consts.svh"
// program memory table, fixed pattern, registered read data
module mstx_table_rom (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [`MSTX_PC_W-1:0] addr_i,
	output logic [`MSTX_ROM_W-1:0] rdata_o
);
	logic [`MSTX_ROM_W-1:0] rdata_reg;

	function automatic logic [`MSTX_ROM_W-1:0] rom_word(input logic [`MSTX_PC_W-1:0] a);
		logic [7:0] hi;
		logic [7:0] lo;
		hi = a[`MSTX_PC_W-1:4] ^ 8'hC3;
		lo = a[7:0] ^ 8'h5A;
		return {hi, lo};
	endfunction

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rom_word(addr_i);
		end
	end

	assign rdata_o = rdata_reg;
endmodule

// File: verification/test_mcu_skip_table_xor_ops.sv
`include "mstx_consts.svh"
module test_mcu_skip_table_xor_ops;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst_n;
	logic [7:0] aw_addr;
	logic [7:0] ar_addr;
	logic aw_valid, w_valid, b_ready, ar_valid, r_ready;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_data;
	int fails;
	int checks;
	logic [31:0] rd;
	logic [1:0] rs;
	logic [7:0] v;
	logic [5:0] flg;
	logic [15:0] tw;

	mstx_exec_core dut (
		.CLOCK_I(clk), .RESET_N_I(rst_n),
		.S_AXI_AWADDR_I(aw_addr), .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_ready),
		.S_AXI_WDATA_I(w_data), .S_AXI_WSTRB_I(w_strb), .S_AXI_WVALID_I(w_valid),
		.S_AXI_WREADY_O(w_ready), .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid),
		.S_AXI_BREADY_I(b_ready), .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid),
		.S_AXI_ARREADY_O(ar_ready), .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp),
		.S_AXI_RVALID_O(r_valid), .S_AXI_RREADY_I(r_ready)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL at %0t: got %08h expected %08h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL at %0t: resp %01h expected %01h", $time, got, exp);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done at %0t", name, $time);
	endtask

	// write cycle: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		resp = 2'h3;
		@(posedge clk);
		aw_addr <= a;
		aw_valid <= 1'b1;
		w_data <= d;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		while (!done && n < 200) begin
			@(posedge clk);
			n++;
			if (aw_valid && aw_ready) aw_valid <= 1'b0;
			if (w_valid && w_ready) w_valid <= 1'b0;
			if (b_valid === 1'b1) begin
				resp = b_resp;
				b_ready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) chk_val(32'h0, 32'h1);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		resp = 2'h3;
		d = 32'h0;
		@(posedge clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		while (!done && n < 200) begin
			@(posedge clk);
			n++;
			if (ar_valid && ar_ready) ar_valid <= 1'b0;
			if (r_valid === 1'b1) begin
				d = r_data;
				resp = r_resp;
				r_ready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) chk_val(32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_resp(r, `MSTX_RESP_OKAY);
	endtask

	task automatic rdv(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_resp(r, `MSTX_RESP_OKAY);
		chk_val(d, exp);
	endtask

	task automatic set_mem(input logic [7:0] a, input logic [7:0] d);
		wr(`MSTX_OFF_MEMADDR, {24'h0, a});
		wr(`MSTX_OFF_MEMDATA, {24'h0, d});
	endtask

	function automatic logic [31:0] ins(logic [3:0] op, logic [2:0] b, logic [7:0] a,
		logic [7:0] im);
		return {8'h00, im, a, 1'b0, b, op};
	endfunction

	function automatic logic [15:0] rom(logic [11:0] a);
		return {a[11:4] ^ 8'hC3, a[7:0] ^ 8'h5A};
	endfunction

	// launch one op, wait for idle, check skip, cycle count, flags and pc step
	task automatic run(input logic [31:0] instr, input logic skip, input logic [5:0] f);
		logic [31:0] pc0;
		logic [31:0] st;
		logic [1:0] r;
		int n;
		n = 0;
		axi_rd(`MSTX_OFF_PC, pc0, r);
		wr(`MSTX_OFF_INSTR, instr);
		do begin
			axi_rd(`MSTX_OFF_STATUS, st, r);
			n++;
		end while (st[8] !== 1'b0 && n < 20);
		chk_val(st, {19'h0, 1'b0, skip ? 2'h2 : 2'h1, skip, 1'b0, 2'h0, f});
		rdv(`MSTX_OFF_PC, {20'h0, pc0[11:0] + (skip ? 12'h002 : 12'h001)});
	endtask

	initial begin
		rst_n = 1'b0;
		aw_addr = 8'h00;
		ar_addr = 8'h00;
		aw_valid = 1'b0;
		w_valid = 1'b0;
		b_ready = 1'b0;
		ar_valid = 1'b0;
		r_ready = 1'b0;
		w_data = 32'h0;
		w_strb = 4'hF;
		fails = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdv(`MSTX_OFF_ACC, 32'h0);
		rdv(`MSTX_OFF_STATUS, 32'h0);
		rdv(`MSTX_OFF_PC, 32'h0);
		axi_wr(8'h40, 32'h0000_00FF, rs);
		chk_resp(rs, `MSTX_RESP_SLVERR);
		axi_rd(8'h40, rd, rs);
		chk_resp(rs, `MSTX_RESP_SLVERR);
		chk_val(rd, 32'h0);
		w_strb <= 4'h0;
		wr(`MSTX_OFF_ACC, 32'h0000_00FF);
		w_strb <= 4'hF;
		rdv(`MSTX_OFF_ACC, 32'h0);
		end_test("bus");

		flg = 6'h3B;
		wr(`MSTX_OFF_STATUS, {26'h0, flg});
		set_mem(8'h10, 8'hA5);
		run(ins(4'h1, 3'h0, 8'h10, 8'h00), 1'b0, flg);
		rdv(`MSTX_OFF_ACC, 32'h0000_005A);
		rdv(`MSTX_OFF_MEMDATA, 32'h0000_00A5);
		end_test("nibble");

		for (int i = 0; i < 2; i++) begin
			v = (i == 0) ? 8'h00 : 8'h80;
			set_mem(8'h20, v);
			run(ins(4'h2, 3'h0, 8'h20, 8'h00), i == 0, flg);
			run(ins(4'h3, 3'h0, 8'h20, 8'h00), i == 0, flg);
			rdv(`MSTX_OFF_ACC, {24'h0, v});
		end
		set_mem(8'h21, 8'hF7);
		run(ins(4'h4, 3'h3, 8'h21, 8'h00), 1'b1, flg);
		run(ins(4'h4, 3'h4, 8'h21, 8'h00), 1'b0, flg);
		rdv(`MSTX_OFF_MEMDATA, 32'h0000_00F7);
		set_mem(8'h22, 8'h01);
		run(ins(4'hA, 3'h0, 8'h22, 8'h00), 1'b1, flg);
		rdv(`MSTX_OFF_MEMDATA, 32'h0000_0000);
		run(ins(4'hA, 3'h0, 8'h22, 8'h00), 1'b0, flg);
		rdv(`MSTX_OFF_MEMDATA, 32'h0000_00FF);
		end_test("skip");

		wr(`MSTX_OFF_PC, 32'h0000_0345);
		wr(`MSTX_OFF_TBLPTR, 32'h0000_007E);
		run(ins(4'h5, 3'h0, 8'h30, 8'h00), 1'b0, flg);
		wr(`MSTX_OFF_MEMADDR, 32'h0000_0030);
		tw = rom(12'h37E);
		rdv(`MSTX_OFF_MEMDATA, {24'h0, tw[7:0]});
		rdv(`MSTX_OFF_TBLHIGH, {24'h0, tw[15:8]});
		run(ins(4'h6, 3'h0, 8'h31, 8'h00), 1'b0, flg);
		wr(`MSTX_OFF_MEMADDR, 32'h0000_0031);
		tw = rom(12'hF7E);
		rdv(`MSTX_OFF_MEMDATA, {24'h0, tw[7:0]});
		rdv(`MSTX_OFF_TBLHIGH, {24'h0, tw[15:8]});
		end_test("table");

		wr(`MSTX_OFF_ACC, 32'h0000_005A);
		set_mem(8'h40, 8'h5A);
		run(ins(4'h7, 3'h0, 8'h40, 8'h00), 1'b0, flg | 6'h04);
		rdv(`MSTX_OFF_ACC, 32'h0000_0000);
		run(ins(4'h9, 3'h0, 8'h00, 8'h0F), 1'b0, flg);
		rdv(`MSTX_OFF_ACC, 32'h0000_000F);
		set_mem(8'h41, 8'hF0);
		run(ins(4'h8, 3'h0, 8'h41, 8'h00), 1'b0, flg);
		rdv(`MSTX_OFF_MEMDATA, 32'h0000_00FF);
		rdv(`MSTX_OFF_ACC, 32'h0000_000F);
		set_mem(8'h42, 8'h0F);
		run(ins(4'h8, 3'h0, 8'h42, 8'h00), 1'b0, flg | 6'h04);
		rdv(`MSTX_OFF_MEMDATA, 32'h0000_0000);
		end_test("xor");
		wr(`MSTX_OFF_INSTR, ins(4'hB, 3'h0, 8'h00, 8'h00));
		rdv(`MSTX_OFF_STATUS, {19'h0, 1'b1, 2'h1, 1'b0, 1'b0, 2'h0, flg | 6'h04});
		end_test("illegal");
		report_and_stop();
	end
endmodule
